// ==== logic/gauge_cmd_regs.sv ====
`timescale 1ns/1ns
module gauge_cmd_regs #(
	parameter logic [7:0] VEL_TOP = 8'hE1      // top table entry
) (
	input  wire logic        CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        CS_N_IN,          // chip select pin
	input  wire logic        SCLK_IN,          // serial clock pin
	input  wire logic        SI_IN,            // serial data in pin
	input  wire logic [1:0]  MOVING_IN,        // per gauge moving
	input  wire logic [15:0] DEV_STATUS_IN,    // device status word
	input  wire logic [15:0] ACCUM_IN,         // accumulator word
	input  wire logic [11:0] POS0_IN,          // gauge zero position
	input  wire logic [11:0] POS1_IN,          // gauge one position
	input  wire logic [15:0] VSTEP_IN,         // velocity step word
	input  wire logic [7:0]  SPEED0_IN,        // gauge zero speed
	input  wire logic [7:0]  SPEED1_IN,        // gauge one speed
	output logic             SO_OUT,           // serial data out
	output logic             SO_OE_OUT,        // serial out enable
	output logic [1:0]       DRIVE_EN_OUT,     // output stage enable
	output logic             STANDBY_OUT,      // low current standby
	output logic             OSC_SLOW_OUT,     // oscillator slowdown
	output logic             CAL_FREQ_OUT,     // calibration target
	output logic             EMU_DIS_OUT,      // emulation disabled
	output logic [1:0]       ZERO_CW_OUT,      // zero at cw end
	output logic [7:0]       VMAX0_OUT,        // gauge zero max index
	output logic [7:0]       VMAX1_OUT,        // gauge one max index
	output logic [1:0]       RAMP_DOWN_OUT,    // slow down request
	output logic [11:0]      TARGET0_OUT,      // gauge zero target
	output logic [11:0]      TARGET1_OUT,      // gauge one target
	output logic             CAL_BUSY_OUT,     // calibration armed
	output logic             CAL_DONE_OUT,     // calibration pulse end
	output logic [11:0]      CAL_COUNT_OUT,    // measured pulse cycles
	output logic             CAL_FAULT_OUT     // counter overrun
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] pin_m_q;    // first stage {cs, sck, si}
	logic [2:0] pin_s_q;    // second stage
	logic [2:0] pin_p_q;    // previous synced value

	// two flops per pin, then one for edges
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			pin_m_q <= 3'h4;
			pin_s_q <= 3'h4;
			pin_p_q <= 3'h4;
		end else begin
			pin_m_q <= {CS_N_IN, SCLK_IN, SI_IN};
			pin_s_q <= pin_m_q;
			pin_p_q <= pin_s_q;
		end
	end

	logic cs_fall;          // chip select falls
	logic cs_rise;          // chip select rises
	logic sck_rise;         // serial clock rises
	logic sck_fall;         // serial clock falls
	logic cs_low;           // transfer window open
	assign cs_fall  = pin_p_q[2] & ~pin_s_q[2];
	assign cs_rise  = ~pin_p_q[2] & pin_s_q[2];
	assign sck_rise = ~pin_p_q[1] & pin_s_q[1];
	assign sck_fall = pin_p_q[1] & ~pin_s_q[1];
	assign cs_low   = ~pin_s_q[2];

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// serial output source from the config
	function automatic logic [15:0] sel_word(input gauge_pkg::cfg_t c);
		logic [11:0] p;
		p = c.out_g ? POS1_IN : POS0_IN;
		if (!c.src_sel)
			sel_word = DEV_STATUS_IN;
		else if (!c.acc_ptr)
			sel_word = ACCUM_IN;
		else if (!c.pos_spd)
			sel_word = {4'h0, p};
		else
			sel_word = VSTEP_IN;
	endfunction : sel_word

	// clamp an index to the table top
	function automatic logic [7:0] clamp(input logic [7:0] i);
		clamp = (i > VEL_TOP) ? VEL_TOP : i;
	endfunction : clamp

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [15:0]       sh_q, sh_d;     // shift register
	logic [3:0]        bit_q, bit_d;   // bits mod 16
	logic              any_q, any_d;   // any bit taken
	logic              so_q, so_d;
	logic              oe_q, oe_d;
	gauge_pkg::cfg_t   cfg_q, cfg_d;
	logic [7:0]        vm0_q, vm0_d;
	logic [7:0]        vm1_q, vm1_d;
	logic [1:0]        rd_q, rd_d;
	logic [11:0]       t0_q, t0_d;
	logic [11:0]       t1_q, t1_d;
	gauge_pkg::cal_t   cal_q, cal_d;
	logic [11:0]       cc_q, cc_d;     // pulse counter
	logic [11:0]       cr_q, cr_d;     // last result
	logic              cd_q, cd_d;     // done pulse
	logic              cf_q, cf_d;     // fault flag
	logic [15:0]       w;              // committed word
	logic [2:0]        addr;
	logic              commit;         // whole word taken
	logic              ok_cfg, ok_vel, ok_pos;
	logic [11:0]       lim;            // counter limit

	assign w    = sh_q;
	assign addr = w[gauge_pkg::ADDR_HI:gauge_pkg::ADDR_LO];
	// whole words only, never during a calibration pulse
	assign commit = cs_rise & any_q & (bit_q == 4'h0)
		& (cal_q != gauge_pkg::CAL_CNT);
	// must-be-zero checks
	assign ok_cfg = ~w[gauge_pkg::B_ZERO6] & ~w[gauge_pkg::B_NULL];
	assign ok_vel = (w[gauge_pkg::VZ_HI:gauge_pkg::VZ_LO] == 3'h0);
	assign ok_pos = ~w[gauge_pkg::B_PZERO];
	assign lim = cfg_q.osc_slow ? gauge_pkg::CALS_CYC
		: gauge_pkg::CALM_CYC;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		sh_d  = sh_q;
		bit_d = bit_q;
		any_d = any_q;
		so_d  = so_q;
		oe_d  = oe_q;
		cfg_d = cfg_q;
		vm0_d = vm0_q;
		vm1_d = vm1_q;
		t0_d  = t0_q;
		t1_d  = t1_q;
		cal_d = cal_q;
		cc_d  = cc_q;
		cr_d  = cr_q;
		cd_d  = 1'b0;
		cf_d  = cf_q;
		// serial shifting, idle during a calibration pulse
		if (cs_fall && cal_q != gauge_pkg::CAL_WAIT) begin
			sh_d  = sel_word(cfg_q);
			bit_d = 4'h0;
			any_d = 1'b0;
			oe_d  = 1'b1;
		end else if (cs_low && cal_q == gauge_pkg::CAL_IDLE) begin
			if (sck_rise) begin
				so_d = sh_q[gauge_pkg::WORD_W-1];
			end
			if (sck_fall) begin
				sh_d  = {sh_q[14:0], pin_s_q[0]};
				bit_d = bit_q + 4'h1;
				any_d = 1'b1;
			end
		end
		if (cs_rise) begin
			oe_d = 1'b0;
		end
		// register commit
		if (commit) begin
			case (addr)
			gauge_pkg::A_CFG: begin
				if (ok_cfg) begin
					cfg_d.drive_en = {w[gauge_pkg::B_EN1],
						w[gauge_pkg::B_EN0]};
					cfg_d.osc_slow = w[gauge_pkg::B_SLOW];
					cfg_d.cal_freq = w[gauge_pkg::B_FSEL];
					cfg_d.emu_dis  = w[gauge_pkg::B_EMU];
					cfg_d.zero_cw[w[gauge_pkg::B_GSEL]] =
						w[gauge_pkg::B_ZLOC];
					cfg_d.src_sel  = w[gauge_pkg::B_SRC];
					cfg_d.acc_ptr  = w[gauge_pkg::B_ACC];
					cfg_d.pos_spd  = w[gauge_pkg::B_PSP];
					cfg_d.out_g    = w[gauge_pkg::B_GSEL];
					if (w[gauge_pkg::B_ARM] && (cfg_q.drive_en == 2'h0
						|| MOVING_IN == 2'h0)) begin
						cal_d = gauge_pkg::CAL_WAIT;
						cf_d  = 1'b0;
					end
				end
			end
			gauge_pkg::A_VEL: begin
				if (ok_vel) begin
					if (w[gauge_pkg::B_VG0]) begin
						vm0_d = clamp(w[gauge_pkg::IDX_W-1:0]);
					end
					if (w[gauge_pkg::B_VG1]) begin
						vm1_d = clamp(w[gauge_pkg::IDX_W-1:0]);
					end
				end
			end
			gauge_pkg::A_POS0: begin
				if (ok_pos) begin
					t0_d = w[gauge_pkg::POS_W-1:0];
				end
			end
			gauge_pkg::A_POS1: begin
				if (ok_pos) begin
					t1_d = w[gauge_pkg::POS_W-1:0];
				end
			end
			default: begin
				// other addresses belong elsewhere
			end
			endcase
		end
		// calibration pulse measurement
		case (cal_q)
		gauge_pkg::CAL_IDLE: begin
		end
		gauge_pkg::CAL_WAIT: begin
			if (cs_fall) begin
				cal_d = gauge_pkg::CAL_CNT;
				cc_d  = 12'h001;
			end
		end
		gauge_pkg::CAL_CNT: begin
			if (cs_rise) begin
				cal_d = gauge_pkg::CAL_IDLE;
				cr_d  = cc_q;
				cd_d  = 1'b1;
				cf_d  = cf_q | (cc_q > lim);
			end else if (cc_q != 12'hFFF) begin
				cc_d = cc_q + 12'h001;
			end
		end
		default: begin
			cal_d = gauge_pkg::CAL_IDLE;
		end
		endcase
	end

	// overspeed against the limits held before this cycle's write
	always_comb begin
		rd_d[0] = (SPEED0_IN > vm0_q);
		rd_d[1] = (SPEED1_IN > vm1_q);
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			sh_q  <= 16'h0000;
			bit_q <= 4'h0;
			any_q <= 1'b0;
			so_q  <= 1'b0;
			oe_q  <= 1'b0;
			cfg_q <= '0;                  // emulation on, drives off
			vm0_q <= VEL_TOP;
			vm1_q <= VEL_TOP;
			rd_q  <= 2'h0;
			t0_q  <= 12'h000;
			t1_q  <= 12'h000;
			cal_q <= gauge_pkg::CAL_IDLE;
			cc_q  <= 12'h000;
			cr_q  <= 12'h000;
			cd_q  <= 1'b0;
			cf_q  <= 1'b0;
		end else begin
			sh_q  <= sh_d;
			bit_q <= bit_d;
			any_q <= any_d;
			so_q  <= so_d;
			oe_q  <= oe_d;
			cfg_q <= cfg_d;
			vm0_q <= vm0_d;
			vm1_q <= vm1_d;
			rd_q  <= rd_d;
			t0_q  <= t0_d;
			t1_q  <= t1_d;
			cal_q <= cal_d;
			cc_q  <= cc_d;
			cr_q  <= cr_d;
			cd_q  <= cd_d;
			cf_q  <= cf_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign SO_OUT        = so_q;
	assign SO_OE_OUT     = oe_q;
	assign DRIVE_EN_OUT  = cfg_q.drive_en;
	assign OSC_SLOW_OUT  = cfg_q.osc_slow;
	assign CAL_FREQ_OUT  = cfg_q.cal_freq;
	assign EMU_DIS_OUT   = cfg_q.emu_dis;
	assign ZERO_CW_OUT   = cfg_q.zero_cw;
	assign VMAX0_OUT     = vm0_q;
	assign VMAX1_OUT     = vm1_q;
	assign RAMP_DOWN_OUT = rd_q;
	assign TARGET0_OUT   = t0_q;
	assign TARGET1_OUT   = t1_q;
	assign CAL_BUSY_OUT  = cal_q[1] | cal_q[2];
	assign CAL_DONE_OUT  = cd_q;
	assign CAL_COUNT_OUT = cr_q;
	assign CAL_FAULT_OUT = cf_q;

	// standby mirrors both drives off, from its own flop
	logic stby_q;
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			stby_q <= 1'b1;
		end else begin
			stby_q <= (cfg_d.drive_en == 2'h0);
		end
	end
	assign STANDBY_OUT = stby_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	sequence s_cal_end;
		(cal_q == gauge_pkg::CAL_CNT) && cs_rise;
	endsequence
	sequence s_cfg_wr;
		commit && addr == gauge_pkg::A_CFG && ok_cfg;
	endsequence

	chk_drive_enable: assert property (s_cfg_wr |=>
		DRIVE_EN_OUT == $past(w[1:0])) else $error("drive enable not taken");
	chk_standby_both: assert property (STANDBY_OUT ==
		(DRIVE_EN_OUT == 2'h0)) else $error("standby mismatch");
	chk_cal_accept: assert property (s_cfg_wr and (w[gauge_pkg::B_ARM]
		&& MOVING_IN != 2'h0 && DRIVE_EN_OUT != 2'h0
		&& cal_q == gauge_pkg::CAL_IDLE) |=> !CAL_BUSY_OUT)
		else $error("calibration accepted while moving");
	chk_cal_fault: assert property (s_cal_end and (cc_q > lim) |=>
		CAL_DONE_OUT && CAL_FAULT_OUT) else $error("overrun not flagged");
	chk_null_cmd: assert property (commit && addr == gauge_pkg::A_CFG
		&& w[gauge_pkg::B_NULL] |=> $stable(cfg_q) && $stable(cal_q))
		else $error("null command changed config");
	chk_vel_clamp: assert property (VMAX0_OUT <= VEL_TOP
		&& VMAX1_OUT <= VEL_TOP) else $error("velocity above table top");
	chk_vel_select: assert property (commit && addr == gauge_pkg::A_VEL
		&& !w[gauge_pkg::B_VG0] |=> $stable(VMAX0_OUT))
		else $error("unselected gauge velocity changed");
	chk_pos_load: assert property (commit && addr == gauge_pkg::A_POS0
		&& ok_pos |=> TARGET0_OUT == $past(w[11:0]))
		else $error("target zero not loaded");
	chk_bad_len: assert property (cs_rise && bit_q != 4'h0
		|=> $stable(TARGET0_OUT) && $stable(TARGET1_OUT))
		else $error("partial word committed");
	chk_so_shift: assert property (cs_low && sck_rise
		&& cal_q == gauge_pkg::CAL_IDLE |=> SO_OUT == $past(sh_q[15]))
		else $error("serial out not msb");
	chk_zero_bits: assert property (commit && addr == gauge_pkg::A_POS1
		&& !ok_pos |=> $stable(TARGET1_OUT)) else $error("invalid word used");
	chk_overspeed: assert property (SPEED0_IN > VMAX0_OUT
		|=> RAMP_DOWN_OUT[0] || $changed(VMAX0_OUT))
		else $error("overspeed not flagged");
endmodule : gauge_cmd_regs

// ==== logic/gauge_pkg.sv ====
package gauge_pkg;
	// ------------------------------------------------------------
	// word layout
	// ------------------------------------------------------------
	localparam int          WORD_W   = 16;          // spi word width
	localparam int          ADDR_HI  = 15;          // register select msb
	localparam int          ADDR_LO  = 13;          // register select lsb
	localparam logic [2:0]  A_CFG    = 3'h0;        // power/enable/cal/config
	localparam logic [2:0]  A_VEL    = 3'h1;        // max velocity
	localparam logic [2:0]  A_POS0   = 3'h2;        // gauge zero target
	localparam logic [2:0]  A_POS1   = 3'h3;        // gauge one target
	// config word bit positions
	localparam int          B_NULL   = 12;          // null command
	localparam int          B_SRC    = 11;          // status source select
	localparam int          B_ACC    = 10;          // accumulator or pointer
	localparam int          B_PSP    = 9;           // position or speed
	localparam int          B_GSEL   = 8;           // output gauge select
	localparam int          B_ZLOC   = 7;           // zero location select
	localparam int          B_ZERO6  = 6;           // must be zero
	localparam int          B_EMU    = 5;           // emulation disable
	localparam int          B_FSEL   = 4;           // calibration freq select
	localparam int          B_ARM    = 3;           // calibration arm
	localparam int          B_SLOW   = 2;           // oscillator slowdown
	localparam int          B_EN1    = 1;           // gauge one drive enable
	localparam int          B_EN0    = 0;           // gauge zero drive enable
	// velocity / position word fields
	localparam int          B_VG1    = 9;           // apply to gauge one
	localparam int          B_VG0    = 8;           // apply to gauge zero
	localparam int          VZ_HI    = 12;          // velocity zero bits msb
	localparam int          VZ_LO    = 10;          // velocity zero bits lsb
	localparam int          IDX_W    = 8;           // velocity index width
	localparam int          B_PZERO  = 12;          // position must be zero
	localparam int          POS_W    = 12;          // target width
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int          CLK_MHZ  = 100;         // system clock rate
	localparam int          CALM_NS  = 10000;       // counter limit, base
	localparam int          CALS_NS  = 15000;       // counter limit, slowed
	localparam int          CNT_W    = 12;          // cal counter width
	localparam logic [11:0] CALM_CYC = 12'(CALM_NS * CLK_MHZ / 1000);
	localparam logic [11:0] CALS_CYC = 12'(CALS_NS * CLK_MHZ / 1000);
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] drive_en;   // per gauge drive enable
		logic       osc_slow;   // oscillator slowdown
		logic       cal_freq;   // calibration frequency select
		logic       emu_dis;    // emulation disable
		logic [1:0] zero_cw;    // per gauge zero at cw end
		logic       src_sel;    // status source select
		logic       acc_ptr;    // accumulator or pointer
		logic       pos_spd;    // position or speed
		logic       out_g;      // output gauge select
	} cfg_t;
	typedef enum logic [2:0] {
		CAL_IDLE = 3'b001,
		CAL_WAIT = 3'b010,
		CAL_CNT  = 3'b100
	} cal_t;
endpackage : gauge_pkg

// ==== testbench/gauge_driver_spi_cmd_regs_tb.sv ====
`timescale 1ns/1ns
module gauge_driver_spi_cmd_regs_tb;
	// ----------------------------------------
	// signals and bench model state
	// ----------------------------------------
	logic        clk, rst, cs_n, sclk, si, so, so_oe, stby, osc_sl, cal_fq;
	logic        emu_d, cal_busy, cal_done, cal_flt, m_sl, m_fq, m_ed;
	logic        m_src, m_acc, m_psp, m_og;
	logic [1:0]  moving, drv_en, zcw, ramp, m_en, m_zc;
	logic [15:0] dev_st, accum, vstep, w;
	logic [11:0] pos0, pos1, tgt0, tgt1, cal_cnt, m_t0, m_t1;
	logic [7:0]  spd0, spd1, vmax0, vmax1, m_v0, m_v1;
	logic [31:0] rx, p;
	int          num_errors, comparisons, seed, cyc, done_cnt, c;
	logic [15:0] tbl [8] = '{16'h4FFF, 16'h6000, 16'h23FF, 16'h21E2,
		16'h2201, 16'h1FFF, 16'h0D83, 16'h0043};
	logic [15:0] cw [4] = '{16'h0008, 16'h0018, 16'h0008, 16'h000C};
	int          cns [4] = '{8000, 8000, 10300, 12000};

	gauge_cmd_regs dut_u (.CLK_IN(clk), .RST_IN(rst), .CS_N_IN(cs_n), .SCLK_IN(sclk),
		.SI_IN(si), .MOVING_IN(moving), .DEV_STATUS_IN(dev_st), .ACCUM_IN(accum),
		.POS0_IN(pos0), .POS1_IN(pos1), .VSTEP_IN(vstep), .SPEED0_IN(spd0),
		.SPEED1_IN(spd1), .SO_OUT(so), .SO_OE_OUT(so_oe), .DRIVE_EN_OUT(drv_en),
		.STANDBY_OUT(stby), .OSC_SLOW_OUT(osc_sl), .CAL_FREQ_OUT(cal_fq),
		.EMU_DIS_OUT(emu_d), .ZERO_CW_OUT(zcw), .VMAX0_OUT(vmax0), .VMAX1_OUT(vmax1),
		.RAMP_DOWN_OUT(ramp), .TARGET0_OUT(tgt0), .TARGET1_OUT(tgt1),
		.CAL_BUSY_OUT(cal_busy), .CAL_DONE_OUT(cal_done), .CAL_COUNT_OUT(cal_cnt),
		.CAL_FAULT_OUT(cal_flt));
	// an undriven serial out shows the inverse, so a late enable is caught
	spi_master_model m_u (.SO_IN(so_oe ? so : ~so), .CS_N_OUT(cs_n), .SCLK_OUT(sclk),
		.SI_OUT(si));

	initial clk = 1'b0;
	always #5 clk = ~clk;
	// hang guard and calibration end counter
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cal_done === 1'b1) done_cnt <= done_cnt + 1;
		if (cyc == 50000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t reg got %h exp %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_so(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] k);
		comparisons++;
		if ((got & k) !== (exp & k)) begin
			num_errors++;
			$display("CHECK FAILED t=%0t serial got %h exp %h", $time, got, exp);
		end
	endtask : chk_so
	task automatic finish_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : finish_test
	// model update for one committed word; bad words change nothing
	task automatic m_apply(input logic [15:0] d);
		case (d[15:13])
			3'h0: if (!d[6] && !d[12]) begin
				m_en = d[1:0];
				{m_sl, m_fq, m_ed} = {d[2], d[4], d[5]};
				m_zc[d[8]] = d[7];
				{m_src, m_acc, m_psp, m_og} = d[11:8];
			end
			3'h1: if (d[12:10] == 3'h0) begin
				if (d[8]) m_v0 = (d[7:0] > 8'hE1) ? 8'hE1 : d[7:0];
				if (d[9]) m_v1 = (d[7:0] > 8'hE1) ? 8'hE1 : d[7:0];
			end
			3'h2: if (!d[12]) m_t0 = d[11:0];
			3'h3: if (!d[12]) m_t1 = d[11:0];
			default: ;
		endcase
	endtask : m_apply
	task automatic chk_all();
		chk_reg({5'h0, so_oe, drv_en, stby, osc_sl, cal_fq, emu_d, zcw, ramp}, {6'h0, m_en,
			m_en == 2'b00, m_sl, m_fq, m_ed, m_zc, spd1 > m_v1, spd0 > m_v0});
		chk_reg({vmax0, vmax1}, {m_v0, m_v1});
		chk_reg({4'h0, tgt0}, {4'h0, m_t0});
		chk_reg({4'h0, tgt1}, {4'h0, m_t1});
	endtask : chk_all
	// one transfer with fresh status sources, then compare serial data and every output except the calibration ones
	task automatic frame(input logic [31:0] d, input int n, input logic [1:0] mv);
		logic [15:0] e, k;
		logic [31:0] q, r;
		p = $random(seed);
		q = $random(seed);
		r = $random(seed);
		@(posedge clk);
		{accum, dev_st} <= p;
		{spd1, spd0, vstep} <= q;
		{pos1, pos0} <= {r[27:16], r[11:0]};
		moving <= mv;
		@(posedge clk);
		e = dev_st;
		k = 16'hFFFF;
		if (m_src) begin
			if (!m_acc) e = accum;
			else if (!m_psp) begin
				e = {4'h0, m_og ? pos1 : pos0};
				k = 16'h0FFF;
			end else begin
				e = vstep;
				k = m_og ? 16'hFFFF : 16'h0000;
			end
		end
		m_u.xfer(d, n, rx);
		repeat (8) @(posedge clk);
		if (n % 16 == 0) m_apply(d[15:0]);
		if (n >= 16) chk_so(rx[n-1 -: 16], e, k);
		if (n == 32) chk_so(rx[15:0], d[31:16], 16'hFFFF);
		chk_all();
	endtask : frame

	initial begin
		seed = 60;
		rst = 1'b1;
		{moving, dev_st, accum, vstep, pos0, pos1, spd0, spd1} = '0;
		{m_en, m_zc, m_sl, m_fq, m_ed, m_src, m_acc, m_psp, m_og, m_t0, m_t1} = '0;
		{m_v0, m_v1} = {8'hE1, 8'hE1};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk_all();
		// random words, mostly well formed, some long or refused
		for (int i = 0; i < 40; i++) begin
			p = $random(seed);
			w = p[15:0];
			if (w[15:13] == 3'h0) w[3] = 1'b0;
			if (p[31:29] != 3'h0) begin
				w[12] = 1'b0;
				if (w[15:13] == 3'h0) w[6] = 1'b0;
				if (w[15:13] == 3'h1) w[11:10] = 2'h0;
			end
			if (w[15:13] == 3'h1 && w[7:0] == 8'h00) w[0] = 1'b1;
			frame({~w, w}, (p[28:27] == 2'b00) ? 32 : 16, p[17:16]);
		end
		frame(32'h0000_4ABC, 12, 2'b00);
		frame(32'h0000_6123, 20, 2'b00);
		for (int i = 0; i < 8; i++) frame({16'h0, tbl[i]}, 16, 2'b01);
		frame(32'h0000_0009, 16, 2'b11);
		chk_reg({15'h0, cal_busy}, 16'h0000);
		// calibration runs: plain, centred, overrun, slowed
		for (int i = 0; i < 4; i++) begin
			frame({16'h0, cw[i]}, 16, {2{i == 1}});
			chk_reg({15'h0, cal_busy}, 16'h0001);
			c = done_cnt;
			m_u.cal_pulse(cns[i]);
			chk_reg({14'h0, cal_busy, cal_flt}, {15'h0, i == 2});
			chk_reg(16'(done_cnt - c), 16'h0001);
			if (i != 2) chk_reg({15'h0, (cal_cnt >= 12'(cns[i] / 10 - 4))
				&& (cal_cnt <= 12'(cns[i] / 10 + 4))}, 16'h0001);
		end
		// reset in mid-run brings back every default
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		{m_en, m_zc, m_sl, m_fq, m_ed, m_src, m_acc, m_psp, m_og, m_t0, m_t1} = '0;
		{m_v0, m_v1} = {8'hE1, 8'hE1};
		repeat (4) @(posedge clk);
		chk_all();
		chk_reg({13'h0, cal_busy, cal_flt, cal_done}, 16'h0000);
		frame({16'h0, 16'h2301}, 16, 2'b00);
		finish_test();
	end
endmodule : gauge_driver_spi_cmd_regs_tb

// ==== testbench/spi_master_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// serial master on the far side of the link
// ----------------------------------------
module spi_master_model (
	input  wire logic SO_IN,    // device serial out
	output logic      CS_N_OUT, // chip select, active low
	output logic      SCLK_OUT, // serial clock, idles low
	output logic      SI_OUT    // serial data to device
);
	// idle: deselected, clock low
	initial begin
		CS_N_OUT = 1'b1;
		SCLK_OUT = 1'b0;
		SI_OUT   = 1'b0;
	end
	// n bits msb first; data set at rise, taken by the device at fall
	task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
		r = '0;
		#3; // keep pin edges off the sampling clock edge
		CS_N_OUT = 1'b0;
		#200;
		for (int i = n - 1; i >= 0; i--) begin
			SI_OUT = w[i];
			SCLK_OUT = 1'b1;
			#63;
			SCLK_OUT = 1'b0;
			r = {r[30:0], SO_IN};
			#62;
		end
		#100;
		CS_N_OUT = 1'b1;
		SI_OUT = ~SI_OUT; // released line shows no stale value
		#200;
	endtask : xfer
	// reference pulse on select alone, no other line moves
	task automatic cal_pulse(input int ns);
		#3; // keep pin edges off the sampling clock edge
		CS_N_OUT = 1'b0;
		#(ns);
		CS_N_OUT = 1'b1;
		#300;
	endtask : cal_pulse
endmodule : spi_master_model
